// file: rtl/ifa_top.sv
// Notes on behaviour
// - low keypad pin latches keypad request
// - converter done raises request when enabled
// - done flag unused while converter interrupts enabled
// - three-bit field selects tick rate
// - chain rollover sets tick flag
// - tick request only when tick enable set
// - writing one to acknowledge clears tick
// - only maskable sources have status flags
// - flags one to eight assigned as listed
// - flags nine to sixteen assigned as listed
// - flag reads one while request present
// - low register holds flags six..one, bits 1:0 zero
// - mid register holds flags fourteen..seven
// - high register holds sixteen,fifteen; upper zero
// - low external pin latches flag one
//
// Our own choices: the APB register port and the register addresses.
`include "ifa_consts.svh"
`default_nettype none
module ifa_top (
  // clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_srst,
  // apb slave
  input  wire ifa_pkg::ifa_apb_req_t i_apb,
  output logic [31:0]               o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  // external pins, asynchronous, active low
  input  wire logic                 i_ext_irq_n,
  input  wire logic [7:0]           i_keypad_pins_n,
  // on-chip sources
  input  wire ifa_pkg::ifa_periph_t i_periph,
  input  wire logic                 i_conv_done,
  // request lines to the cpu core
  output logic [15:0]               o_irq_req
);
  import ifa_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic       ext_s1_r;             // first stage, read only by second
  logic       ext_s2_r;             // synchronised external pin
  logic [7:0] key_s1_r;             // first stage keypad
  logic [7:0] key_s2_r;             // synchronised keypad

  // two flops per pin before any logic
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
      key_s1_r <= 8'hff;
      key_s2_r <= 8'hff;
    end else begin
      ext_s1_r <= i_ext_irq_n;
      ext_s2_r <= ext_s1_r;
      key_s1_r <= i_keypad_pins_n;
      key_s2_r <= key_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // bus decode
  logic wr_en;                      // write access phase
  logic rd_en;                      // read access phase
  logic hit_low, hit_mid, hit_high; // status registers
  logic hit_tick, hit_conv, hit_key;// control registers
  logic hit_any;                    // mapped address

  // a write lands only at the edge where the master sees pready high
  assign wr_en    = i_apb.psel & i_apb.penable & i_apb.pwrite & o_pready;
  assign rd_en    = i_apb.psel & i_apb.penable & ~i_apb.pwrite;
  assign hit_low  = (i_apb.paddr == `IFA_OFF_FLAGS_LOW);
  assign hit_mid  = (i_apb.paddr == `IFA_OFF_FLAGS_MID);
  assign hit_high = (i_apb.paddr == `IFA_OFF_FLAGS_HIGH);
  assign hit_tick = (i_apb.paddr == `IFA_OFF_TICK_CTRL);
  assign hit_conv = (i_apb.paddr == `IFA_OFF_CONV_CTRL);
  assign hit_key  = (i_apb.paddr == `IFA_OFF_KEY_CTRL);
  assign hit_any  = hit_low | hit_mid | hit_high | hit_tick | hit_conv | hit_key;

  logic tick_wr, conv_wr, key_wr;   // register writes
  assign tick_wr = wr_en & hit_tick;
  assign conv_wr = wr_en & hit_conv;
  assign key_wr  = wr_en & hit_key;

  ////////////////////////////////////////////////////////////////////
  // control registers
  logic [2:0] tick_rate_select_r;   // timebase rate field
  logic       tick_irq_enable_r;    // timebase interrupt enable
  logic       tick_on_r;            // timebase counter running
  logic       conv_irq_enable_r;    // converter interrupt enable

  // software-written control bits
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      tick_rate_select_r <= `IFA_RST_TICK_RATE;
      tick_irq_enable_r  <= 1'b0;
      tick_on_r          <= 1'b0;
      conv_irq_enable_r  <= 1'b0;
    end else begin
      if (tick_wr) begin
        tick_rate_select_r <= i_apb.pwdata[`IFA_TICK_RATE_LSB +: 3];
        tick_irq_enable_r  <= i_apb.pwdata[`IFA_TICK_IE_BIT];
        tick_on_r          <= i_apb.pwdata[`IFA_TICK_ON_BIT];
      end
      if (conv_wr) begin
        conv_irq_enable_r <= i_apb.pwdata[`IFA_CONV_IE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // timebase counter chain
  logic [18:0] chain_r;             // free counter
  logic [4:0]  tap_sel;             // period exponent
  logic        rollover;            // chain wrapped at selected tap
  logic [18:0] tap_mask;            // low bits that must be ones

  assign tap_sel  = `IFA_TICK_BASE_LOG2 + (5'(tick_rate_select_r) << 1);
  assign tap_mask = 19'((20'h00001 << tap_sel) - 20'h00001);
  assign rollover = tick_on_r & ((chain_r & tap_mask) == tap_mask);

  // chain runs while enabled, cleared when stopped
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      chain_r <= 19'h00000;
    end else if (!tick_on_r) begin
      chain_r <= 19'h00000;
    end else begin
      chain_r <= chain_r + 19'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // latched requests
  logic tick_flag_r;                // timebase flag
  logic key_pend_r;                 // keypad request latch
  logic ext_pend_r;                 // external pin request latch
  logic conv_done_flag_r;           // converter done flag
  logic tick_ack, key_ack, ext_ack; // acknowledge writes
  logic conv_req;                   // converter request to cpu
  logic tick_req;                   // timebase request to cpu

  assign tick_ack = tick_wr & i_apb.pwdata[`IFA_TICK_ACK_BIT];
  assign key_ack  = key_wr & i_apb.pwdata[`IFA_KEY_ACK_BIT];
  assign ext_ack  = key_wr & i_apb.pwdata[`IFA_EXT_ACK_BIT];

  // set wins over acknowledge in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      tick_flag_r      <= 1'b0;
      key_pend_r       <= 1'b0;
      ext_pend_r       <= 1'b0;
      conv_done_flag_r <= 1'b0;
    end else begin
      tick_flag_r <= rollover | (tick_flag_r & ~tick_ack);
      key_pend_r  <= (~&key_s2_r) | (key_pend_r & ~key_ack);
      ext_pend_r  <= ~ext_s2_r | (ext_pend_r & ~ext_ack);
      // done flag only tracks completion while interrupts are off
      conv_done_flag_r <= (i_conv_done & ~conv_irq_enable_r) |
                          (conv_done_flag_r & ~conv_wr & ~conv_irq_enable_r);
    end
  end

  // converter interrupt pending, cleared by any converter control write
  logic conv_pend_r;                // converter request latch
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      conv_pend_r <= 1'b0;
    end else begin
      conv_pend_r <= (i_conv_done & conv_irq_enable_r) |
                     (conv_pend_r & ~conv_wr & conv_irq_enable_r);
    end
  end

  assign conv_req = conv_pend_r;
  assign tick_req = tick_flag_r & tick_irq_enable_r;

  ////////////////////////////////////////////////////////////////////
  // flag vector, index 0 is flag one; no reset or soft instr flag
  logic [15:0] flags;               // present requests
  assign flags = {tick_req,         // flag 16
                  conv_req,         // flag 15
                  key_pend_r,       // flag 14
                  i_periph.src,     // flags 13..2
                  ext_pend_r};      // flag 1

  // status bytes, read-only, upper flag in upper bit
  logic [7:0] low_byte, mid_byte, high_byte;
  assign low_byte  = {flags[5:0], 2'b00};
  assign mid_byte  = flags[13:6];
  assign high_byte = {6'h00, flags[15:14]};

  // control readback
  logic [7:0] tick_byte, conv_byte, key_byte;
  assign tick_byte = {tick_on_r, 1'b0, tick_flag_r, tick_irq_enable_r,
                      1'b0, tick_rate_select_r};
  assign conv_byte = {6'h00, conv_done_flag_r, conv_irq_enable_r};
  assign key_byte  = {4'h0, ext_pend_r, 1'b0, key_pend_r, 1'b0};

  // read mux; writes to status offsets fall through unused
  logic [7:0] rd_byte;              // selected register
  assign rd_byte = hit_low  ? low_byte  :
                   hit_mid  ? mid_byte  :
                   hit_high ? high_byte :
                   hit_tick ? tick_byte :
                   hit_conv ? conv_byte :
                   hit_key  ? key_byte  : 8'h00;

  ////////////////////////////////////////////////////////////////////
  // apb answer: ready in the second access cycle (one wait state), error on unmapped
  logic pready_nxt;                 // access phase seen
  assign pready_nxt = i_apb.psel & i_apb.penable & ~o_pready;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h00000000;
    end else begin
      o_pready  <= pready_nxt;
      o_pslverr <= pready_nxt & ~hit_any;
      o_prdata  <= (pready_nxt & ~i_apb.pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // registered request lines to the cpu
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_irq_req <= 16'h0000;
    end else begin
      o_irq_req <= flags;
    end
  end
endmodule
`default_nettype wire

// file: rtl/ifa_consts.svh
`ifndef IFA_CONSTS_SVH
`define IFA_CONSTS_SVH
// register byte offsets on the apb bus
`define IFA_OFF_FLAGS_LOW   12'h000
`define IFA_OFF_FLAGS_MID   12'h004
`define IFA_OFF_FLAGS_HIGH  12'h008
`define IFA_OFF_TICK_CTRL   12'h00c
`define IFA_OFF_CONV_CTRL   12'h010
`define IFA_OFF_KEY_CTRL    12'h014
// tick control fields
`define IFA_TICK_RATE_LSB   0
`define IFA_TICK_IE_BIT     4
`define IFA_TICK_FLAG_BIT   5
`define IFA_TICK_ACK_BIT    6
`define IFA_TICK_ON_BIT     7
// converter control fields
`define IFA_CONV_IE_BIT     0
`define IFA_CONV_DONE_BIT   1
// keypad control fields
`define IFA_KEY_ACK_BIT     0
`define IFA_KEY_PEND_BIT    1
`define IFA_EXT_ACK_BIT     2
`define IFA_EXT_PEND_BIT    3
// reset values
`define IFA_RST_TICK_RATE   3'h0
`define IFA_RST_BYTE        8'h00
// timebase chain: rate n gives period of 2**(base+2n) cycles
`define IFA_TICK_BASE_LOG2  5'h03
`define IFA_TICK_STEP_LOG2  5'h02
`endif

// file: rtl/ifa_pkg.sv
`default_nettype none
package ifa_pkg;
  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ifa_apb_req_t;
  // request lines of the peripherals (flags 2..13)
  typedef struct packed {
    logic [11:0] src;
  } ifa_periph_t;
endpackage
`default_nettype wire

// file: sim/ifa_top_properties.sv
`default_nettype none
module ifa_top_checker (
  // watched ports
  input wire logic                  i_clk_sys,
  input wire logic                  i_srst,
  input wire ifa_pkg::ifa_apb_req_t i_apb,
  input wire logic [31:0]           o_prdata,
  input wire logic                  o_pready,
  input wire logic                  o_pslverr,
  input wire logic                  i_ext_irq_n,
  input wire logic [7:0]            i_keypad_pins_n,
  input wire ifa_pkg::ifa_periph_t  i_periph,
  input wire logic                  i_conv_done,
  input wire logic [15:0]           o_irq_req
);
  import ifa_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // bus handshake timing
  a_ready_after_access: assert property (i_apb.psel && i_apb.penable && !o_pready |=> o_pready)
    else $error("pready late");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready) else $error("pready held");
  a_err_with_ready: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("stray slave error");
  a_rdata_idle_zero: assert property (!o_pready |-> o_prdata == 32'h0) else $error("rdata leak");
  // fixed zero bits of the status bytes
  a_low_bits_zero: assert property (o_pready && !i_apb.pwrite && i_apb.paddr == 12'h000 |->
    o_prdata[1:0] == 2'h0) else $error("low status bits set");
  a_high_bits_zero: assert property (o_pready && !i_apb.pwrite && i_apb.paddr == 12'h008 |->
    o_prdata[7:2] == 6'h00) else $error("high status bits set");
  // pin latching and peripheral mapping
  a_ext_pin_flag: assert property (!i_ext_irq_n |-> ##[1:6] o_irq_req[0])
    else $error("ext pin not latched");
  a_key_pin_flag: assert property (i_keypad_pins_n != 8'hff |-> ##[1:6] o_irq_req[13])
    else $error("keypad pin not latched");
  a_periph_flag_map: assert property (!$past(i_srst) |-> o_irq_req[12:1] == $past(i_periph.src))
    else $error("peripheral flag mismatch");
endmodule
bind ifa_top ifa_top_checker u_chk (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_apb(i_apb),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_ext_irq_n(i_ext_irq_n),
  .i_keypad_pins_n(i_keypad_pins_n), .i_periph(i_periph), .i_conv_done(i_conv_done),
  .o_irq_req(o_irq_req));
`default_nettype wire

// file: sim/ifa_periph_model.sv
`default_nettype none
module ifa_periph_model (
  input  wire logic        i_clk_sys,
  input  wire logic [11:0] i_src,
  input  wire logic        i_done,
  output logic [11:0]      o_src,
  output logic             o_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // peripherals present request levels in step with the bus clock
  always_ff @(posedge i_clk_sys) begin
    o_src  <= i_src;
    o_done <= i_done;
  end
endmodule
`default_nettype wire

// file: sim/ifa_top_tb.sv
`include "ifa_consts.svh"
`default_nettype none
module ifa_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ifa_pkg::*;
  logic         clk = 1'b0, srst = 1'b1, ext_n = 1'b1, conv = 1'b0, pdone, pready, pslverr;
  logic [7:0]   key_n = 8'hff;
  logic [11:0]  src = 12'h000, psrc;
  logic [15:0]  irq;
  logic [31:0]  prdata;
  ifa_apb_req_t req = '0;
  int           miscompares = 0, tests_run = 0;
  ifa_periph_model model (.i_clk_sys(clk), .i_src(src), .i_done(conv), .o_src(psrc),
    .o_done(pdone));
  ifa_top uut (.i_clk_sys(clk), .i_srst(srst), .i_apb(req), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ext_irq_n(ext_n), .i_keypad_pins_n(key_n),
    .i_periph(ifa_periph_t'(psrc)), .i_conv_done(pdone), .o_irq_req(irq));
  // free-running bus clock
  initial forever #2 clk = ~clk;
  task automatic conclude();
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk(32'h0, 32'h1);
      conclude();
    end
    q = prdata;
    e = pslverr;
    req <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = '1);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q & m, x);
    chk({31'h0, e}, {31'h0, a > `IFA_OFF_KEY_CTRL});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  // all three status bytes and the request lines against one flag vector
  task automatic st(input logic [15:0] f);
    rd(`IFA_OFF_FLAGS_LOW, {24'h0, f[5:0], 2'b00});
    rd(`IFA_OFF_FLAGS_MID, {24'h0, f[13:6]});
    rd(`IFA_OFF_FLAGS_HIGH, {30'h0, f[15:14]});
    chk({16'h0, irq}, {16'h0, f});
  endtask
  task automatic pulse();
    conv <= 1'b1;
    @(posedge clk);
    conv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    st(16'h0000);
    for (int k = 0; k < 12; k++) begin
      src <= 12'h001 << k;
      repeat (3) @(posedge clk);
      st(16'h0002 << k);
    end
    src <= 12'hfff;
    wr(`IFA_OFF_FLAGS_LOW, 32'h000000ff);
    wr(`IFA_OFF_FLAGS_HIGH, 32'h000000ff);
    st(16'h1ffe);
    src <= 12'h000;
    ext_n <= 1'b0;
    key_n <= 8'hef;
    repeat (6) @(posedge clk);
    ext_n <= 1'b1;
    key_n <= 8'hff;
    st(16'h2001);
    wr(`IFA_OFF_KEY_CTRL, 32'h00000005);
    st(16'h0000);
    rd(12'h020, 32'h0);
    wr(`IFA_OFF_CONV_CTRL, 32'h00000001);
    pulse();
    st(16'h4000);
    rd(`IFA_OFF_CONV_CTRL, 32'h00000001);
    wr(`IFA_OFF_CONV_CTRL, 32'h00000000);
    pulse();
    rd(`IFA_OFF_CONV_CTRL, 32'h00000002);
    st(16'h0000);
    wr(`IFA_OFF_TICK_CTRL, 32'h00000080);
    repeat (20) @(posedge clk);
    rd(`IFA_OFF_TICK_CTRL, 32'h00000020, 32'h00000020);
    st(16'h0000);
    wr(`IFA_OFF_TICK_CTRL, 32'h00000090);
    st(16'h8000);
    wr(`IFA_OFF_TICK_CTRL, 32'h00000010);
    st(16'h8000);
    wr(`IFA_OFF_TICK_CTRL, 32'h00000050);
    st(16'h0000);
    wr(`IFA_OFF_TICK_CTRL, 32'h00000087);
    rd(`IFA_OFF_TICK_CTRL, 32'h00000007, 32'h00000007);
    conclude();
  end
endmodule
`default_nettype wire
